// ===== inc/frpd_pkg.sv
// Constants and types for the fast read parameter word bank.
// ============================================================
package frpd_pkg;
    // ============================================================
    // Register map
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_SUP = 5'h00;
    localparam logic [4:0] OFS_DUAL = 5'h04;
    localparam logic [4:0] OFS_QUAD = 5'h08;
    localparam logic [4:0] OFS_CTRL = 5'h0c;
    localparam logic [4:0] OFS_STAT = 5'h10;
    // ============================================================
    // Field layout
    localparam int SUP_QUAD_BIT = 4;
    localparam int SUP_DUAL_BIT = 0;
    localparam int OP_LSB = 24;
    localparam int MODE_LSB = 21;
    localparam int DUMMY_LSB = 16;
    localparam int MODE_MAX = 7;
    localparam int DUMMY_MAX = 31;
    localparam logic [26:0] RSVD_SUP_HI = 27'h7ff_ffff;
    localparam logic [2:0] RSVD_SUP_MID = 3'h7;
    localparam logic [15:0] RSVD_LO = 16'hffff;
    localparam int LAT_W = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_ERR_BIT = 0;
    localparam int CNT_LSB = 16;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ============================================================
    // Default advertised values
    localparam logic DEF_SUP = 1'b1;
    localparam logic [7:0] DEF_OP = 8'h00;
    localparam int DEF_MODE = 2;
    localparam int DEF_DUMMY = 4;
    // ============================================================
    // Bus states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACK = 2'b10
    } frpd_state_e;
endpackage

// ===== inc/frpd_word_if.sv
// Interface carrying the assembled parameter words.
`timescale 1ns/1ps
interface frpd_word_if;
    logic [31:0] word [0:2];
    modport src (output word);
    modport snk (input word);
endinterface

// ===== hw/frpd_rom.sv
// Constant parameter word assembler.
`timescale 1ns/1ps
module frpd_rom
    import frpd_pkg::*;
#(
    parameter logic DUAL_SUP = DEF_SUP,
    parameter logic [7:0] DUAL_OP = DEF_OP,
    parameter logic [2:0] DUAL_MODE = 3'h2,
    parameter logic [4:0] DUAL_DUMMY = 5'h04,
    parameter logic QUAD_SUP = DEF_SUP,
    parameter logic [7:0] QUAD_OP = DEF_OP,
    parameter logic [2:0] QUAD_MODE = 3'h2,
    parameter logic [4:0] QUAD_DUMMY = 5'h04
)
(
    frpd_word_if.src words
);
    // ============================================================
    // Mode words
    localparam logic [7:0] OPS [0:1] = '{DUAL_OP, QUAD_OP};
    localparam logic [2:0] MODES [0:1] = '{DUAL_MODE, QUAD_MODE};
    localparam logic [4:0] DUMMIES [0:1] = '{DUAL_DUMMY, QUAD_DUMMY};

    genvar m;
    for (m = 0; m < 2; m++)
    begin : g_mode
        // Opcode, mode clocks, dummy clocks, reserved ones.
        assign words.word[m + 1] = {OPS[m], MODES[m], DUMMIES[m], RSVD_LO};
    end

    // ============================================================
    // Support word
    assign words.word[0] = {RSVD_SUP_HI, QUAD_SUP, RSVD_SUP_MID, DUAL_SUP};
endmodule // frpd_rom

// ===== hw/frpd_regs.sv
// Avalon-MM slave serving the fast read parameter words.
`timescale 1ns/1ps
module frpd_regs
    import frpd_pkg::*;
#(
    parameter logic DUAL_SUP = DEF_SUP,
    parameter logic [7:0] DUAL_OP = DEF_OP,
    parameter int DUAL_MODE = DEF_MODE,
    parameter int DUAL_DUMMY = DEF_DUMMY,
    parameter logic QUAD_SUP = DEF_SUP,
    parameter logic [7:0] QUAD_OP = DEF_OP,
    parameter int QUAD_MODE = DEF_MODE,
    parameter int QUAD_DUMMY = DEF_DUMMY
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic [1:0] response_o,
    output logic waitrequest_o
);
    // ============================================================
    // Elaboration checks
    localparam int MODES [0:1] = '{DUAL_MODE, QUAD_MODE};
    localparam int DUMMIES [0:1] = '{DUAL_DUMMY, QUAD_DUMMY};
    localparam logic SUPS [0:1] = '{DUAL_SUP, QUAD_SUP};

    genvar k;
    for (k = 0; k < 2; k++)
    begin : g_chk
        if (MODES[k] < 0 || MODES[k] > MODE_MAX)
        begin : g_bad_mode
            $error("Mode clock count does not fit its field.");
        end
        if (DUMMIES[k] < 0 || DUMMIES[k] > DUMMY_MAX)
        begin : g_bad_dummy
            $error("Dummy clock count does not fit its field.");
        end
        // A supported mode with no dummy clocks lets both ends drive the lines.
        if (SUPS[k] && DUMMIES[k] == 0)
        begin : g_no_dummy
            $error("Supported mode advertises zero dummy clocks.");
        end
    end

    // ============================================================
    // Parameter words
    frpd_word_if u_words ();

    frpd_rom #(
        .DUAL_SUP(DUAL_SUP),
        .DUAL_OP(DUAL_OP),
        .DUAL_MODE(3'(DUAL_MODE)),
        .DUAL_DUMMY(5'(DUAL_DUMMY)),
        .QUAD_SUP(QUAD_SUP),
        .QUAD_OP(QUAD_OP),
        .QUAD_MODE(3'(QUAD_MODE)),
        .QUAD_DUMMY(5'(QUAD_DUMMY))
    ) u_rom (
        .words(u_words)
    );

    // ============================================================
    // Bus state
    frpd_state_e state_r;
    frpd_state_e state_nxt;
    logic [LAT_W-1:0] cnt_r;
    logic [LAT_W-1:0] cnt_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic wr_r;
    logic wr_nxt;
    logic wait_r;
    logic wait_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] resp_r;
    logic [1:0] resp_nxt;

    // ============================================================
    // Control and status state
    logic [LAT_W-1:0] lat_r;
    logic [LAT_W-1:0] lat_nxt;
    logic err_r;
    logic err_nxt;
    logic [CNT_W-1:0] rdcnt_r;
    logic [CNT_W-1:0] rdcnt_nxt;

    // ============================================================
    // Decode
    logic hit;
    logic param_hit;
    logic [31:0] rd_mux;
    logic done;

    always_comb
    begin
        param_hit = (addr_r == OFS_SUP) || (addr_r == OFS_DUAL) || (addr_r == OFS_QUAD);
        hit = param_hit || (addr_r == OFS_CTRL) || (addr_r == OFS_STAT);
        case (addr_r)
            OFS_SUP: rd_mux = u_words.word[0];
            OFS_DUAL: rd_mux = u_words.word[1];
            OFS_QUAD: rd_mux = u_words.word[2];
            OFS_CTRL: rd_mux = {{(32 - LAT_W){1'b0}}, lat_r};
            OFS_STAT: rd_mux = {rdcnt_r, 15'h0000, err_r};
            default: rd_mux = 32'h0000_0000;
        endcase
        done = (state_r == ST_ACK);
    end

    // ============================================================
    // Bus handshake
    // The request is latched on entry, so a master that holds it steady
    // sees one answer whose latency is set by the control register.
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wr_nxt = wr_r;
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        resp_nxt = resp_r;
        case (state_r)
            ST_IDLE:
            begin
                if (read_i || write_i)
                begin
                    state_nxt = ST_WAIT;
                    cnt_nxt = lat_r;
                    addr_nxt = address_i;
                    wr_nxt = write_i;
                end
            end
            ST_WAIT:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = ST_ACK;
                    wait_nxt = 1'b0;
                    rdata_nxt = wr_r ? 32'h0000_0000 : rd_mux;
                    resp_nxt = hit ? RESP_OK : RESP_SLVERR;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_ACK:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            addr_r <= '0;
            wr_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            resp_r <= RESP_OK;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            resp_r <= resp_nxt;
        end
    end

    assign waitrequest_o = wait_r;
    assign readdata_o = rdata_r;
    assign response_o = resp_r;

    // ============================================================
    // Control and status registers
    // Writes land at the edge that completes the transfer, when the
    // master still holds its data. Parameter words ignore writes.
    always_comb
    begin
        lat_nxt = lat_r;
        err_nxt = err_r;
        rdcnt_nxt = rdcnt_r;
        if (done && wr_r && addr_r == OFS_CTRL && byteenable_i[0])
        begin
            lat_nxt = writedata_i[LAT_W-1:0];
        end
        if (done && wr_r && addr_r == OFS_STAT && byteenable_i[0] && writedata_i[STAT_ERR_BIT])
        begin
            err_nxt = 1'b0;
        end
        // A new miss in the clearing cycle must not be lost.
        if (done && !hit)
        begin
            err_nxt = 1'b1;
        end
        if (done && !wr_r && param_hit)
        begin
            rdcnt_nxt = rdcnt_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lat_r <= CTRL_RST;
            err_r <= 1'b0;
            rdcnt_r <= CNT_RST;
        end
        else
        begin
            lat_r <= lat_nxt;
            err_r <= err_nxt;
            rdcnt_r <= rdcnt_nxt;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    logic ack_rd;
    assign ack_rd = !wait_r && !wr_r;

    a_rsvd_sup_ones:
    assert property (ack_rd && addr_r == OFS_SUP |-> readdata_o[31:5] == RSVD_SUP_HI && readdata_o[3:1] == RSVD_SUP_MID)
    else $error("Reserved support bits did not read as ones.");

    a_rsvd_mode_ones:
    assert property (ack_rd && (addr_r == OFS_DUAL || addr_r == OFS_QUAD) |-> readdata_o[15:0] == RSVD_LO)
    else $error("Reserved mode word bits did not read as ones.");

    a_quad_sup_flag:
    assert property (ack_rd && addr_r == OFS_SUP |-> readdata_o[SUP_QUAD_BIT] == QUAD_SUP)
    else $error("Quad support flag is wrong.");

    a_dual_sup_flag:
    assert property (ack_rd && addr_r == OFS_SUP |-> readdata_o[SUP_DUAL_BIT] == DUAL_SUP)
    else $error("Dual support flag is wrong.");

    a_dual_opcode:
    assert property (ack_rd && addr_r == OFS_DUAL |-> readdata_o[31:OP_LSB] == DUAL_OP)
    else $error("Dual opcode is wrong.");

    a_dual_mode_clk:
    assert property (ack_rd && addr_r == OFS_DUAL |-> readdata_o[23:MODE_LSB] == 3'(DUAL_MODE))
    else $error("Dual mode clock count is wrong.");

    a_dual_dummy_clk:
    assert property (ack_rd && addr_r == OFS_DUAL |-> readdata_o[20:DUMMY_LSB] == 5'(DUAL_DUMMY))
    else $error("Dual dummy clock count is wrong.");

    a_quad_opcode:
    assert property (ack_rd && addr_r == OFS_QUAD |-> readdata_o[31:OP_LSB] == QUAD_OP)
    else $error("Quad opcode is wrong.");

    a_quad_mode_clk:
    assert property (ack_rd && addr_r == OFS_QUAD |-> readdata_o[23:MODE_LSB] == 3'(QUAD_MODE))
    else $error("Quad mode clock count is wrong.");

    a_quad_dummy_clk:
    assert property (ack_rd && addr_r == OFS_QUAD |-> readdata_o[20:DUMMY_LSB] == 5'(QUAD_DUMMY))
    else $error("Quad dummy clock count is wrong.");

    a_dummy_nonzero:
    assert property (u_words.word[0][SUP_DUAL_BIT] |-> u_words.word[1][20:DUMMY_LSB] != 5'h00)
    else $error("Supported dual mode advertises no dummy clocks.");

    a_answer_bound:
    assert property (state_r == ST_IDLE && (read_i || write_i) |-> waitrequest_o [*2] ##[1:4] !waitrequest_o)
    else $error("Answer did not arrive in time.");

    a_single_ack:
    assert property (!waitrequest_o |=> waitrequest_o)
    else $error("Waitrequest stayed low for more than one cycle.");

    a_miss_slverr:
    assert property (state_r == ST_WAIT && cnt_r == '0 && !hit |=> response_o == RESP_SLVERR ##1 err_r)
    else $error("Unmapped access was not flagged.");

    a_lat_stretch:
    assert property (state_r == ST_IDLE && (read_i || write_i) && lat_r == 2'h3 |=> waitrequest_o [*4] ##1 !waitrequest_o)
    else $error("Programmed latency was not honoured.");
endmodule // frpd_regs

// ===== tb/frpd_host_model.sv
// Host model that reads the parameter words over Avalon-MM and plans fast read line driving.
`timescale 1ns/1ps
module frpd_host_model
    import frpd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    input wire logic [1:0] response_i,
    output logic [ADDR_W-1:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o
);
    // ============================================================
    // Bus transfers
    initial
    begin
        address_o = 5'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0000_0000;
        byteenable_o = 4'hf;
    end

    // The request is held until waitrequest is seen low or 20 cycles pass, so an answer within that bound never loses a write.
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be,
                        output logic [31:0] rd, output logic [1:0] rsp, output logic ok, output int n);
        n = 0;
        @(posedge mclk_i);
        address_o <= a;
        read_o <= !wr;
        write_o <= wr;
        writedata_o <= wd;
        byteenable_o <= be;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (waitrequest_i !== 1'b0 && n < 20);
        ok = (waitrequest_i === 1'b0);
        rd = readdata_i;
        rsp = response_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
        writedata_o <= ~wd;
    endtask

    // ============================================================
    // Fast read planning
    // Says whether the host drives the data lines in cycle c after the address phase.
    function automatic logic drives_lines(input logic [31:0] sup, input logic quad, input logic [31:0] w,
                                          input int c);
        if (!sup[quad ? 4 : 0])
            return 1'b0;
        return c < int'(w[23:21]);
    endfunction
endmodule // frpd_host_model

// ===== tb/fast_read_param_dwords_test.sv
// Self-checking bench for the fast read parameter word bank.
`timescale 1ns/1ps
module fast_read_param_dwords_test
    import frpd_pkg::*;
;
    localparam logic D_SUP = 1'b1;
    localparam logic Q_SUP = 1'b0;
    localparam logic [7:0] D_OP = 8'ha5;
    localparam logic [7:0] Q_OP = 8'h5a;
    localparam logic [2:0] D_MODE = 3'h3;
    localparam logic [2:0] Q_MODE = 3'h7;
    localparam logic [4:0] D_DUMMY = 5'h05;
    localparam logic [4:0] Q_DUMMY = 5'h1f;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic [1:0] response;
    logic waitrequest;
    logic [31:0] last_rd;
    logic [31:0] words [0:2];
    logic [1:0] lat = 2'h0;
    logic [15:0] cnt = 16'h0000;
    logic miss = 1'b0;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 74;

    always #4 mclk = ~mclk;

    frpd_regs #(.DUAL_SUP(D_SUP), .DUAL_OP(D_OP), .DUAL_MODE(D_MODE), .DUAL_DUMMY(D_DUMMY),
                .QUAD_SUP(Q_SUP), .QUAD_OP(Q_OP), .QUAD_MODE(Q_MODE), .QUAD_DUMMY(Q_DUMMY)) DUT (
        .mclk_i(mclk), .rst_i(rst), .address_i(address), .read_i(read), .write_i(write),
        .writedata_i(writedata), .byteenable_i(byteenable), .readdata_o(readdata),
        .response_o(response), .waitrequest_o(waitrequest));

    frpd_host_model HOST (
        .mclk_i(mclk), .waitrequest_i(waitrequest), .readdata_i(readdata), .response_i(response),
        .address_o(address), .read_o(read), .write_o(write), .writedata_o(writedata),
        .byteenable_o(byteenable));

    // ============================================================
    // Checking helpers
    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] exp_word(input logic [4:0] a);
        case (a)
            OFS_SUP: return {27'h7ff_ffff, Q_SUP, 3'h7, D_SUP};
            OFS_DUAL: return {D_OP, D_MODE, D_DUMMY, 16'hffff};
            OFS_QUAD: return {Q_OP, Q_MODE, Q_DUMMY, 16'hffff};
            OFS_CTRL: return {30'h0000_0000, lat};
            default: return 32'h0000_0000;
        endcase
    endfunction

    // One transfer with every answer compared, then the bench's view of the bank updated.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be);
        logic [1:0] rsp;
        logic ok;
        logic mapped;
        int n;
        HOST.xfer(wr, a, wd, be, last_rd, rsp, ok, n);
        if (ok !== 1'b1)
        begin
            err_count++;
            finish_test();
        end
        else
        begin
            mapped = (a == OFS_SUP) || (a == OFS_DUAL) || (a == OFS_QUAD) || (a == OFS_CTRL) || (a == OFS_STAT);
            check("wait_cycles", n, 3 + lat);
            check("response", rsp, mapped ? RESP_OK : RESP_SLVERR);
            if (!wr && a != OFS_STAT)
                check("readdata", last_rd, exp_word(a));
            if (!wr && a == OFS_STAT)
            begin
                check("stat_count", last_rd[31:16], cnt);
                check("stat_zero", last_rd[15:1], 32'h0000_0000);
                check("stat_error", last_rd[0], miss);
            end
            // The flag clear only lands when byte lane 0 is enabled.
            if (!mapped)
                miss = 1'b1;
            else if (wr && a == OFS_CTRL && be[0])
                lat = wd[1:0];
            else if (wr && a == OFS_STAT && wd[0] && be[0])
                miss = 1'b0;
            else if (!wr && a != OFS_CTRL && a != OFS_STAT)
                cnt++;
        end
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        logic [4:0] a;
        logic wr;
        logic [31:0] wd;
        repeat (20)
        begin
            @(negedge mclk);
            check("wait_in_reset", waitrequest, 1'b1);
            check("data_in_reset", readdata, 32'h0000_0000);
            check("resp_in_reset", response, RESP_OK);
        end
        @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, 5'(4 * i), 32'h0000_0000, 4'hf);
            words[i] = last_rd;
        end
        check("dual_dummy_nonzero", words[1][20:16] != 5'h00, 1'b1);
        check("drive_mode_cycle", HOST.drives_lines(words[0], 1'b0, words[1], 2), 1'b1);
        check("release_dummy_cycle", HOST.drives_lines(words[0], 1'b0, words[1], 3), 1'b0);
        check("quad_unused", HOST.drives_lines(words[0], 1'b1, words[2], 0), 1'b0);
        // A write to a read-only word, an unaligned access and a flag clear, back to back.
        bus(1'b1, OFS_DUAL, 32'h0000_0000, 4'hf);
        bus(1'b0, OFS_DUAL, 32'h0000_0000, 4'hf);
        bus(1'b0, 5'h05, 32'h0000_0000, 4'hf);
        bus(1'b0, OFS_STAT, 32'h0000_0000, 4'hf);
        bus(1'b1, OFS_STAT, 32'h0000_0001, 4'h1);
        bus(1'b0, OFS_STAT, 32'h0000_0000, 4'hf);
        for (int l = 0; l < 4; l++)
        begin
            bus(1'b1, OFS_CTRL, 32'(l), 4'h1);
            bus(1'b0, OFS_QUAD, 32'h0000_0000, 4'hf);
        end
        repeat (150)
        begin
            a = ($random(seed) & 1) ? 5'(($random(seed) & 3) * 4) : 5'($random(seed));
            wr = ($random(seed) & 3) == 0;
            wd = $random(seed);
            if (a == OFS_STAT)
                wd = {31'h0000_0000, wd[0]};
            bus(wr, a, wd, 4'($random(seed)));
        end
        bus(1'b0, OFS_STAT, 32'h0000_0000, 4'hf);
        // A second reset must bring latency, flag and counter back to zero.
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        lat = 2'h0;
        cnt = 16'h0000;
        miss = 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0000_0000, 4'hf);
        bus(1'b0, OFS_STAT, 32'h0000_0000, 4'hf);
        finish_test();
    end
endmodule // fast_read_param_dwords_test
